// ==== design/cfd_pkg.sv ====
// cfd_pkg: constants, register map and carrier types of the current fault delay block
// assumes a 10 MHz system clock and a 32-bit Avalon-MM register port
package cfd_pkg;

	// clock and timing
	localparam int CLK_MHZ           = 10;
	localparam int OCD_BASE_MS       = 1;
	localparam int OCD_STEP_MS       = 2;
	localparam int MS_US             = 1000;
	localparam int OCD_MS_CYCLES     = MS_US * CLK_MHZ;
	localparam int SC_STEP_US        = 61;
	localparam int SC_STEP_CYCLES    = SC_STEP_US * CLK_MHZ;
	localparam int WD_WINDOW_MS      = 100;
	localparam int WD_WINDOW_CYCLES  = WD_WINDOW_MS * OCD_MS_CYCLES;
	localparam int DLY_W             = 24;

	// threshold scale in mV with the sense range at full scale
	localparam int OCD_BASE_MV       = 50;
	localparam int OCD_STEP_MV       = 10;
	localparam int SCC_BASE_MV       = 100;
	localparam int SCC_STEP_MV       = 50;
	localparam int SCC_FULL_MAX_CODE = 4;
	localparam int SCD_BASE_MV       = 100;
	localparam int SCD_STEP_MV       = 50;
	localparam int MV_W              = 11;

	// register byte offsets
	localparam logic [4:0] OFS_CONTROL   = 5'h00;
	localparam logic [4:0] OFS_THRESHOLD = 5'h04;
	localparam logic [4:0] OFS_DELAY     = 5'h08;
	localparam logic [4:0] OFS_STATUS    = 5'h0C;
	localparam logic [4:0] OFS_MASK      = 5'h10;

	// field positions
	localparam int CTL_HALVE_BIT  = 0;
	localparam int CTL_DOUBLE_BIT = 1;
	localparam int CTL_ENABLE_BIT = 2;
	localparam int THR_OCD_LSB    = 0;
	localparam int THR_SCD_LSB    = 8;
	localparam int THR_SCC_LSB    = 16;
	localparam int DLY_OCD_LSB    = 0;
	localparam int DLY_SCD_LSB    = 8;
	localparam int DLY_SCC_LSB    = 16;
	localparam int STA_LIVE_LSB   = 8;
	localparam int STA_WD_BIT     = 12;

	// fault indices
	localparam int F_OCD = 0;
	localparam int F_SCD = 1;
	localparam int F_SCC = 2;
	localparam int NFAULT = 3;

	// reset values
	localparam logic [2:0]  CONTROL_RST = 3'h4;
	localparam logic [3:0]  CODE4_RST   = 4'h0;
	localparam logic [2:0]  CODE3_RST   = 3'h0;
	localparam logic [2:0]  MASK_RST    = 3'h0;
	localparam logic [31:0] WORD_ZERO   = 32'h00000000;

	typedef struct packed {
		logic       protectEnable;
		logic       shortDischargeDelayDoubling;
		logic       senseRangeHalving;
	} cfd_control_t;

	typedef struct packed {
		logic [2:0] shortCircuitCharge;
		logic [2:0] shortCircuitDischarge;
		logic [3:0] overcurrentDischarge;
	} cfd_thresh_t;

	typedef struct packed {
		logic [3:0] shortChargeDelay;
		logic [3:0] shortDischargeDelay;
		logic [3:0] overcurrentDischargeDelay;
	} cfd_delay_t;

	typedef struct packed {
		logic [MV_W-1:0] shortCircuitCharge;
		logic [MV_W-1:0] shortCircuitDischarge;
		logic [MV_W-1:0] overcurrentDischarge;
	} cfd_levels_t;

endpackage

// ==== design/current_fault_delay_protection.sv ====
// current_fault_delay_protection: threshold codes, fault qualification delays,
// sticky fault status with read-clear, interrupt mask and an Avalon-MM slave
// assumes comparator and watchdog inputs already synchronous to clk
module current_fault_delay_protection
	import cfd_pkg::*;
#(
	parameter int MS_CYCLES        = OCD_MS_CYCLES,
	parameter int WATCHDOG_CYCLES  = WD_WINDOW_CYCLES
) (
	input  wire logic              clk,
	input  wire logic              rst_n,
	input  wire logic              ce,
	// Avalon-MM slave
	input  wire logic [4:0]        address,
	input  wire logic              read,
	input  wire logic              write,
	input  wire logic [31:0]       writedata,
	input  wire logic [3:0]        byteenable,
	output logic      [31:0]       readdata,
	output logic                   waitrequest,
	// comparator results from the sense-resistor front end
	input  wire logic              cmpOvercurrentDischarge,
	input  wire logic              cmpShortCircuitDischarge,
	input  wire logic              cmpShortCircuitCharge,
	input  wire logic              watchdogInputPulse,
	// programmed levels to the comparator references
	output logic                   senseRangeHalving,
	output cfd_levels_t            thresholdMv,
	// qualified faults and interrupt
	output logic [NFAULT-1:0]      faultLatched,
	output logic                   irq
);

	cfd_control_t           control_ff;
	cfd_thresh_t            thresh_ff;
	cfd_delay_t             delay_ff;
	logic [NFAULT-1:0]      status_ff;
	logic [NFAULT-1:0]      mask_ff;
	logic [31:0]            readdata_ff;
	logic                   waitrequest_ff;
	logic                   senseRangeHalving_ff;
	cfd_levels_t            levels_ff;
	logic                   irq_ff;
	logic [DLY_W-1:0]       cnt_ff [NFAULT];
	logic [NFAULT-1:0]      tripped_ff;
	logic [NFAULT-1:0]      event_ff;
	logic                   wdPrev_ff;
	logic [DLY_W-1:0]       wdAge_ff;
	logic                   wdActive_ff;

	logic                   accept;
	logic                   grant;
	logic                   wrControl;
	logic                   wrThresh;
	logic                   wrDelay;
	logic                   wrMask;
	logic                   rdStatus;
	logic [31:0]            wmask;
	logic [NFAULT-1:0]      cmp;
	logic [DLY_W-1:0]       target [NFAULT];
	logic [31:0]            nxt_readdata;
	logic [31:0]            thrWord;
	logic [31:0]            dlyWord;
	logic [NFAULT-1:0]      nxt_status;
	logic [NFAULT-1:0]      clrMask;
	logic [31:0]            ctlWord;
	logic [31:0]            mskWord;
	logic [31:0]            ctlMerged;
	logic [31:0]            thrMerged;
	logic [31:0]            dlyMerged;
	logic [31:0]            mskMerged;
	logic                   wdEdge;
	logic                   wdExpired;

	// threshold magnitude in mV; halving scales base and step alike
	function automatic logic [MV_W-1:0] levelMv(input int baseMv, input int stepMv,
		input logic [3:0] code, input logic halve);
		int mv;
		mv = baseMv + stepMv * int'(code);
		if (halve)
			mv = mv / 2;
		return mv[MV_W-1:0];
	endfunction

	// qualification delay in clock cycles
	function automatic logic [DLY_W-1:0] delayCycles(input int baseSteps, input int perCode,
		input logic [3:0] code, input int stepCycles);
		int cyc;
		cyc = (baseSteps + perCode * int'(code)) * stepCycles;
		return cyc[DLY_W-1:0];
	endfunction

	// byte-lane merge of a write into the current register image
	function automatic logic [31:0] laneMerge(input logic [31:0] cur, input logic [31:0] wr,
		input logic [31:0] lanes);
		return (wr & lanes) | (cur & ~lanes);
	endfunction

	// bus decode: one wait state, then accept on the edge with waitrequest low
	assign grant     = (read | write) & waitrequest_ff;
	assign accept    = (read | write) & ~waitrequest_ff;
	assign wrControl = accept & write & (address == OFS_CONTROL);
	assign wrThresh  = accept & write & (address == OFS_THRESHOLD);
	assign wrDelay   = accept & write & (address == OFS_DELAY);
	assign wrMask    = accept & write & (address == OFS_MASK);
	assign rdStatus  = accept & read & (address == OFS_STATUS);
	assign wmask     = {{8{byteenable[3]}}, {8{byteenable[2]}},
		{8{byteenable[1]}}, {8{byteenable[0]}}};

	assign cmp = {cmpShortCircuitCharge, cmpShortCircuitDischarge, cmpOvercurrentDischarge};

	always_comb begin
		thrWord = WORD_ZERO;
		thrWord[THR_OCD_LSB +: 4] = thresh_ff.overcurrentDischarge;
		thrWord[THR_SCD_LSB +: 3] = thresh_ff.shortCircuitDischarge;
		thrWord[THR_SCC_LSB +: 3] = thresh_ff.shortCircuitCharge;
		dlyWord = WORD_ZERO;
		dlyWord[DLY_OCD_LSB +: 4] = delay_ff.overcurrentDischargeDelay;
		dlyWord[DLY_SCD_LSB +: 4] = delay_ff.shortDischargeDelay;
		dlyWord[DLY_SCC_LSB +: 4] = delay_ff.shortChargeDelay;
		ctlWord = WORD_ZERO;
		ctlWord[CTL_HALVE_BIT]  = control_ff.senseRangeHalving;
		ctlWord[CTL_DOUBLE_BIT] = control_ff.shortDischargeDelayDoubling;
		ctlWord[CTL_ENABLE_BIT] = control_ff.protectEnable;
		mskWord = WORD_ZERO;
		mskWord[NFAULT-1:0] = mask_ff;
	end

	assign ctlMerged = laneMerge(ctlWord, writedata, wmask);
	assign thrMerged = laneMerge(thrWord, writedata, wmask);
	assign dlyMerged = laneMerge(dlyWord, writedata, wmask);
	assign mskMerged = laneMerge(mskWord, writedata, wmask);

	always_comb begin
		nxt_readdata = WORD_ZERO;
		case (address)
			OFS_CONTROL: begin
				nxt_readdata[CTL_HALVE_BIT]  = control_ff.senseRangeHalving;
				nxt_readdata[CTL_DOUBLE_BIT] = control_ff.shortDischargeDelayDoubling;
				nxt_readdata[CTL_ENABLE_BIT] = control_ff.protectEnable;
			end
			OFS_THRESHOLD: nxt_readdata = thrWord;
			OFS_DELAY:     nxt_readdata = dlyWord;
			OFS_STATUS: begin
				nxt_readdata[NFAULT-1:0] = status_ff;
				nxt_readdata[STA_LIVE_LSB +: NFAULT] = cmp;
				nxt_readdata[STA_WD_BIT] = wdActive_ff;
			end
			OFS_MASK:      nxt_readdata[NFAULT-1:0] = mask_ff;
			default:       nxt_readdata = WORD_ZERO;
		endcase
	end

	// one wait state per access; low for exactly the accept cycle
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitrequest_ff <= 1'b1;
		end else if (ce) begin
			waitrequest_ff <= ~grant;
		end
	end

	// read data captured at grant; zero after a write grant
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			readdata_ff <= WORD_ZERO;
		end else if (ce && grant) begin
			readdata_ff <= read ? nxt_readdata : WORD_ZERO;
		end
	end

	// control register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			control_ff <= CONTROL_RST;
		end else if (ce && wrControl) begin
			control_ff.senseRangeHalving           <= ctlMerged[CTL_HALVE_BIT];
			control_ff.shortDischargeDelayDoubling <= ctlMerged[CTL_DOUBLE_BIT];
			control_ff.protectEnable               <= ctlMerged[CTL_ENABLE_BIT];
		end
	end

	// threshold codes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			thresh_ff <= {CODE3_RST, CODE3_RST, CODE4_RST};
		end else if (ce && wrThresh) begin
			thresh_ff.overcurrentDischarge  <= thrMerged[THR_OCD_LSB +: 4];
			thresh_ff.shortCircuitDischarge <= thrMerged[THR_SCD_LSB +: 3];
			thresh_ff.shortCircuitCharge    <= thrMerged[THR_SCC_LSB +: 3];
		end
	end

	// delay codes
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			delay_ff <= {CODE4_RST, CODE4_RST, CODE4_RST};
		end else if (ce && wrDelay) begin
			delay_ff.overcurrentDischargeDelay <= dlyMerged[DLY_OCD_LSB +: 4];
			delay_ff.shortDischargeDelay       <= dlyMerged[DLY_SCD_LSB +: 4];
			delay_ff.shortChargeDelay          <= dlyMerged[DLY_SCC_LSB +: 4];
		end
	end

	// interrupt mask
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mask_ff <= MASK_RST;
		end else if (ce && wrMask) begin
			mask_ff <= mskMerged[NFAULT-1:0];
		end
	end

	// comparator reference levels
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			senseRangeHalving_ff <= 1'b0;
			levels_ff            <= '0;
		end else if (ce) begin
			senseRangeHalving_ff <= control_ff.senseRangeHalving;
			levels_ff.overcurrentDischarge <= levelMv(OCD_BASE_MV, OCD_STEP_MV,
				thresh_ff.overcurrentDischarge, control_ff.senseRangeHalving);
			levels_ff.shortCircuitDischarge <= levelMv(SCD_BASE_MV, SCD_STEP_MV,
				{1'b0, thresh_ff.shortCircuitDischarge},
				control_ff.senseRangeHalving);
			// charge level is a negative voltage; magnitude is carried
			if (!control_ff.senseRangeHalving
				&& thresh_ff.shortCircuitCharge > SCC_FULL_MAX_CODE[2:0])
				levels_ff.shortCircuitCharge <= levelMv(SCC_BASE_MV, SCC_STEP_MV,
					SCC_FULL_MAX_CODE[3:0], 1'b0);
			else
				levels_ff.shortCircuitCharge <= levelMv(SCC_BASE_MV, SCC_STEP_MV,
					{1'b0, thresh_ff.shortCircuitCharge},
					control_ff.senseRangeHalving);
		end
	end

	// delay targets in cycles; exact clock count keeps error far inside tolerance
	always_comb begin
		target[F_OCD] = delayCycles(OCD_BASE_MS, OCD_STEP_MS,
			delay_ff.overcurrentDischargeDelay, MS_CYCLES);
		target[F_SCD] = delayCycles(0, control_ff.shortDischargeDelayDoubling ? 2 : 1,
			delay_ff.shortDischargeDelay, SC_STEP_CYCLES);
		target[F_SCC] = delayCycles(0, 1, delay_ff.shortChargeDelay,
			SC_STEP_CYCLES);
	end

	// per-fault qualification counters; one event per comparator assertion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < NFAULT; i++)
				cnt_ff[i] <= '0;
			tripped_ff <= '0;
			event_ff   <= '0;
		end else if (ce) begin
			for (int i = 0; i < NFAULT; i++) begin
				event_ff[i] <= 1'b0;
				if (!cmp[i] || !control_ff.protectEnable) begin
					cnt_ff[i]     <= '0;
					tripped_ff[i] <= 1'b0;
				end else if (!tripped_ff[i]) begin
					if (cnt_ff[i] >= target[i]) begin
						tripped_ff[i] <= 1'b1;
						event_ff[i]   <= 1'b1;
					end else begin
						cnt_ff[i] <= cnt_ff[i] + 1'b1;
					end
				end
			end
		end
	end

	// sticky status; a read clears only the bits it returned, so a fault that
	// lands between grant and accept is kept; a new fault beats the clear
	assign clrMask    = rdStatus ? readdata_ff[NFAULT-1:0] : {NFAULT{1'b0}};
	assign nxt_status = (status_ff & ~clrMask) | event_ff;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			status_ff <= '0;
		end else if (ce) begin
			status_ff <= nxt_status;
		end
	end

	// level interrupt follows the status it is computed from
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_ff <= 1'b0;
		end else if (ce) begin
			irq_ff <= |(nxt_status & mask_ff);
		end
	end

	assign wdEdge    = watchdogInputPulse != wdPrev_ff;
	assign wdExpired = wdAge_ff >= WATCHDOG_CYCLES[DLY_W-1:0];

	// watchdog pin history for edge detection
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdPrev_ff <= 1'b0;
		end else if (ce) begin
			wdPrev_ff <= watchdogInputPulse;
		end
	end

	// cycles since the last watchdog edge, held at the window
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdAge_ff <= '0;
		end else if (ce) begin
			if (wdEdge) begin
				wdAge_ff <= '0;
			end else if (!wdExpired) begin
				wdAge_ff <= wdAge_ff + 1'b1;
			end
		end
	end

	// any edge within the window marks the watchdog active
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdActive_ff <= 1'b0;
		end else if (ce) begin
			if (wdEdge) begin
				wdActive_ff <= 1'b1;
			end else if (wdExpired) begin
				wdActive_ff <= 1'b0;
			end
		end
	end

	assign readdata          = readdata_ff;
	assign waitrequest       = waitrequest_ff;
	assign senseRangeHalving = senseRangeHalving_ff;
	assign thresholdMv       = levels_ff;
	assign faultLatched      = status_ff;
	assign irq               = irq_ff;

endmodule // current_fault_delay_protection

// ==== testbench/cfd_checker.sv ====
// cfd_checker: port assertions of the current fault delay block
// assumes binding onto current_fault_delay_protection, one clock domain
module cfd_checker
	import cfd_pkg::*;
(
	input wire logic              clk,
	input wire logic              rst_n,
	input wire logic              ce,
	input wire logic [4:0]        address,
	input wire logic              read,
	input wire logic              write,
	input wire logic              waitrequest,
	input wire logic              senseRangeHalving,
	input wire cfd_levels_t       thresholdMv,
	input wire logic [NFAULT-1:0] faultLatched,
	input wire logic              irq
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0]  upCnt_ff;
	logic [1:0]  halvePrev_ff;
	logic        settled;
	logic        clrGrant;
	logic        halve;
	logic [10:0] overMv;
	logic [10:0] shortDisMv;
	logic [10:0] shortChgMv;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			upCnt_ff     <= 2'h0;
			halvePrev_ff <= 2'h0;
		end else begin
			upCnt_ff     <= (upCnt_ff == 2'h3) ? upCnt_ff : upCnt_ff + 2'h1;
			halvePrev_ff <= {halvePrev_ff[0], senseRangeHalving};
		end
	end
	assign halve      = senseRangeHalving;
	// levels judged only once the range bit has stood still
	assign settled    = (upCnt_ff == 2'h3) && (halvePrev_ff == {2{halve}});
	assign clrGrant   = read && !waitrequest && ce && (address == OFS_STATUS);
	assign overMv     = thresholdMv.overcurrentDischarge;
	assign shortDisMv = thresholdMv.shortCircuitDischarge;
	assign shortChgMv = thresholdMv.shortCircuitCharge;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence sReq;
		(read || write) && waitrequest && ce;
	endsequence
	sequence sGrant;
		!waitrequest && ce;
	endsequence
	AST_BUS_ONE_WAIT: assert property (sReq |=> !waitrequest)
		else $error("no grant one cycle after request");
	AST_BUS_ONE_LOW: assert property (sGrant |=> waitrequest)
		else $error("grant longer than one cycle");
	AST_BUS_IDLE: assert property (!read && !write && waitrequest |=> waitrequest)
		else $error("grant without request");
	AST_IRQ_CAUSE: assert property (faultLatched == 3'h0 |-> !irq)
		else $error("interrupt without latched fault");
	AST_STICKY: assert property (!clrGrant && !$past(clrGrant) |=>
		(faultLatched & $past(faultLatched)) == $past(faultLatched))
		else $error("latched fault lost without status read");
	AST_OVER_RANGE: assert property (settled |-> overMv >= 50 >> halve && overMv <= 200 >> halve)
		else $error("overcurrent level out of range");
	AST_OVER_STEP: assert property (settled |-> overMv % (halve ? 5 : 10) == 0)
		else $error("overcurrent level off step");
	AST_SCHG_RANGE: assert property (settled |-> shortChgMv >= 100 >> halve &&
		shortChgMv <= (halve ? 225 : 300))
		else $error("charge short level out of range");
	AST_SCHG_STEP: assert property (settled |-> shortChgMv % (halve ? 25 : 50) == 0)
		else $error("charge short level off step");
	AST_SDIS_RANGE: assert property (settled |-> shortDisMv >= 100 >> halve &&
		shortDisMv <= 450 >> halve)
		else $error("discharge short level out of range");
	AST_SDIS_STEP: assert property (settled |-> shortDisMv % (halve ? 25 : 50) == 0)
		else $error("discharge short level off step");
endmodule // cfd_checker

bind current_fault_delay_protection cfd_checker i_chk (.clk(clk), .rst_n(rst_n), .ce(ce),
	.address(address), .read(read), .write(write), .waitrequest(waitrequest),
	.senseRangeHalving(senseRangeHalving), .thresholdMv(thresholdMv),
	.faultLatched(faultLatched), .irq(irq));

// ==== testbench/cfd_front_end_model.sv ====
// cfd_front_end_model: sense comparators and a toggling watchdog source
// assumes senseMv in mV from the bench, positive while discharging
module cfd_front_end_model
	import cfd_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst_n,
	input  wire logic signed [15:0] senseMv,
	input  wire cfd_levels_t        thresholdMv,
	output logic                    cmpOvercurrentDischarge,
	output logic                    cmpShortCircuitDischarge,
	output logic                    cmpShortCircuitCharge,
	output logic                    watchdogInputPulse
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [2:0] wdCnt_ff;
	// trips while the sense is beyond the programmed level
	assign cmpOvercurrentDischarge  = senseMv > $signed({5'h00, thresholdMv.overcurrentDischarge});
	assign cmpShortCircuitDischarge = senseMv > $signed({5'h00, thresholdMv.shortCircuitDischarge});
	assign cmpShortCircuitCharge    = -senseMv > $signed({5'h00, thresholdMv.shortCircuitCharge});
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wdCnt_ff           <= 3'h0;
			watchdogInputPulse <= 1'h0;
		end else begin
			wdCnt_ff <= wdCnt_ff + 3'h1;
			if (wdCnt_ff == 3'h7) begin
				watchdogInputPulse <= !watchdogInputPulse;
			end
		end
	end
endmodule // cfd_front_end_model

// ==== testbench/current_fault_delay_protection_tb.sv ====
// current_fault_delay_protection_tb: self-checking bench of the fault delay block
// assumes cfd_pkg, the front end model and the bound checker compiled first
module current_fault_delay_protection_tb
	import cfd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int MSC = 20;
	logic               clk;
	logic               rst_n;
	logic [4:0]         address;
	logic               read;
	logic               write;
	logic [31:0]        writedata;
	logic [31:0]        readdata;
	logic               waitrequest;
	logic signed [15:0] senseMv;
	logic               cmpO;
	logic               cmpD;
	logic               cmpC;
	logic               wdPulse;
	logic               halveOut;
	logic               irq;
	cfd_levels_t        levels;
	logic [2:0]         fault;
	int                 err_total;
	int                 checks;
	always #50 clk = !clk;
	current_fault_delay_protection #(.MS_CYCLES(MSC), .WATCHDOG_CYCLES(50)) i_dut (.clk(clk),
		.rst_n(rst_n), .ce(1'h1), .address(address), .read(read), .write(write),
		.writedata(writedata), .byteenable(4'hF), .readdata(readdata),
		.waitrequest(waitrequest), .cmpOvercurrentDischarge(cmpO),
		.cmpShortCircuitDischarge(cmpD), .cmpShortCircuitCharge(cmpC),
		.watchdogInputPulse(wdPulse), .senseRangeHalving(halveOut),
		.thresholdMv(levels), .faultLatched(fault), .irq(irq));
	cfd_front_end_model i_fe (.clk(clk), .rst_n(rst_n), .senseMv(senseMv), .thresholdMv(levels),
		.cmpOvercurrentDischarge(cmpO), .cmpShortCircuitDischarge(cmpD),
		.cmpShortCircuitCharge(cmpC), .watchdogInputPulse(wdPulse));
	task automatic test_done();
		if (err_total == 0 && checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cmp_span(input int n, input int t);
		checks++;
		if (n < t + 2 || n > t + 6) begin
			err_total++;
			$display("unexpected at %0t: fault after %0d cycles, delay %0d", $time, n, t);
		end
	endtask
	task automatic bus(input logic rd, input logic [4:0] a, input logic [31:0] d,
			output logic [31:0] q);
		int n = 0;
		address <= a;
		writedata <= d;
		read <= rd;
		write <= !rd;
		do begin
			@(posedge clk);
			n++;
		end while (waitrequest !== 1'h0 && n < 20);
		q = readdata;
		read <= 1'h0;
		write <= 1'h0;
		if (n == 20) begin
			err_total++;
			$display("unexpected at %0t: no bus answer", $time);
		end
		@(posedge clk);
	endtask
	// drives the sense until the fault shows, then clears status
	task automatic meas(input int idx, input logic signed [15:0] mv, output int n);
		logic [31:0] q;
		n = 0;
		senseMv <= mv;
		while (fault[idx] !== 1'h1 && n < 20000) begin
			@(posedge clk);
			n++;
		end
		senseMv <= 16'sh0;
		bus(1'h1, OFS_STATUS, 32'h0, q);
	endtask
	task automatic t_regs();
		logic [31:0] q;
		logic [4:0] adr [5] = '{OFS_CONTROL, OFS_THRESHOLD, OFS_DELAY, OFS_MASK, 5'h14};
		bus(1'h0, 5'h14, 32'hFFFFFFFF, q);
		foreach (adr[i]) begin
			bus(1'h1, adr[i], 32'h0, q);
			cmp_val(q, (i == 0) ? 32'h4 : 32'h0);
		end
	endtask
	task automatic t_levels();
		logic [31:0] q;
		int c3;
		int s;
		for (int h = 0; h < 2; h++) begin
			bus(1'h0, OFS_CONTROL, 32'h4 | 32'(h), q);
			for (int c = 0; c < 16; c++) begin
				c3 = c % 8;
				s = (h == 1 || c3 < 4) ? c3 : 4;
				bus(1'h0, OFS_THRESHOLD, 32'(c3 << 16 | c3 << 8 | c), q);
				repeat (2) @(posedge clk);
				cmp_val(32'(halveOut), 32'(h));
				cmp_val(32'(levels.overcurrentDischarge), 32'((50 + 10 * c) >> h));
				cmp_val(32'(levels.shortCircuitDischarge), 32'((100 + 50 * c3) >> h));
				cmp_val(32'(levels.shortCircuitCharge), 32'((100 + 50 * s) >> h));
			end
		end
		bus(1'h0, OFS_CONTROL, 32'h4, q);
		bus(1'h0, OFS_THRESHOLD, 32'h0, q);
	endtask
	// sense 13 mV beyond the reset overcurrent level
	task automatic t_over_delay();
		logic [31:0] q;
		int n;
		int codes [3] = '{0, 7, 15};
		foreach (codes[i]) begin
			bus(1'h0, OFS_DELAY, 32'(codes[i]), q);
			meas(0, 16'sh3F, n);
			cmp_span(n, (1 + 2 * codes[i]) * MSC);
		end
	endtask
	task automatic t_short_delays();
		logic [31:0] q;
		int n;
		int codes [3] = '{0, 1, 15};
		for (int d = 0; d < 2; d++) begin
			bus(1'h0, OFS_CONTROL, 32'h4 | 32'(d << 1), q);
			for (int f = 1; f < 3; f++) begin
				foreach (codes[i]) begin
					bus(1'h0, OFS_DELAY, 32'(codes[i] << (8 * f)), q);
					meas(f, (f == 1) ? 16'sh71 : -16'sh71, n);
					cmp_span(n, codes[i] * SC_STEP_CYCLES * ((f == 1) ? d + 1 : 1));
				end
			end
		end
		bus(1'h0, OFS_CONTROL, 32'h4, q);
	endtask
	task automatic t_restart();
		logic [31:0] q;
		int n;
		bus(1'h0, OFS_DELAY, 32'h0, q);
		senseMv <= 16'sh3F;
		repeat (MSC / 2) @(posedge clk);
		senseMv <= 16'sh0;
		@(posedge clk);
		cmp_val(32'(fault), 32'h0);
		meas(0, 16'sh3F, n);
		cmp_span(n, MSC);
	endtask
	task automatic t_irq();
		logic [31:0] q;
		senseMv <= -16'sh71;
		repeat (60) @(posedge clk);
		senseMv <= 16'sh0;
		repeat (3) @(posedge clk);
		cmp_val({irq, fault}, 4'h4);
		bus(1'h0, OFS_MASK, 32'h4, q);
		repeat (3) @(posedge clk);
		cmp_val({irq, fault}, 4'hC);
		bus(1'h1, OFS_STATUS, 32'h0, q);
		cmp_val(q & 32'h1007, 32'h1004);
		repeat (3) @(posedge clk);
		cmp_val({irq, fault}, 4'h0);
	endtask
	initial begin
		clk = 1'h0;
		rst_n = 1'h0;
		read = 1'h0;
		write = 1'h0;
		address = 5'h00;
		writedata = 32'h0;
		senseMv = 16'sh0;
		err_total = 0;
		checks = 0;
		repeat (6) @(posedge clk);
		rst_n <= 1'h1;
		@(posedge clk);
		t_regs();
		t_levels();
		t_over_delay();
		t_short_delays();
		t_restart();
		t_irq();
		test_done();
	end
	initial begin
		repeat (80000) @(posedge clk);
		err_total++;
		test_done();
	end
endmodule // current_fault_delay_protection_tb
